/* rtl/twowire_slave_engine.sv */
// slave engine of the two-wire serial unit with its wishbone register file
`timescale 1ns/1ps
`include "twowire_map.svh"

// Function
// - status codes always read with prescaler bits zero
// - general call data posts 0x90, acks per enable
// - unacked general call data posts 0x98, unaddressed
// - stop or restart while addressed as receiver posts 0xA0
// - re-recognition needs ack enable, general call enable
// - start request issues start once bus free
// - match upper seven address bits against master
// - address lsb enables general call address response
// - read bit enters transmit, write bit receive
// - address received sets flag with valid status
// - lost arbitration then read-addressed posts 0xB0
// - cleared ack enable makes current byte last
// - last byte posts 0xC0 on nack, 0xC8 ack
// - after last byte release data, ignore master
// - ack enable low means own address ignored
// - keep watching bus, resume when enable set
// - hold clock low after match until flag cleared
module twowire_slave_engine (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        arb_lost_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  localparam int HD_STA_CYC = `TW_HD_STA_CYC;

  // ----------------------------------------------------------------------
  // line synchronisers and event detection
  // ----------------------------------------------------------------------
  twowire_evt_if ev ();
  logic [1:0] lines_s;

  twowire_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (lines_s)
  );

  twowire_line_events u_events (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .scl_i (lines_s[1]),
    .sda_i (lines_s[0]),
    .ev    (ev)
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  twowire_pkg::slave_state_t state_r;
  twowire_pkg::byte_t        sh_r;
  twowire_pkg::byte_t        data_r;
  twowire_pkg::byte_t        status_r;
  twowire_pkg::byte_t        adr_r;
  twowire_pkg::byte_t        post_code;
  logic [3:0]                cnt_r;
  logic [7:0]                gen_cnt_r;
  logic                      flag_r;
  logic                      acken_r;
  logic                      sta_r;
  logic                      sto_r;
  logic                      wc_r;
  logic                      en_r;
  logic                      ie_r;
  logic                      sda_drv_r;
  logic                      gc_r;
  logic                      rw_r;
  logic                      last_r;
  logic                      ackgiven_r;
  logic                      nack_r;
  logic                      arb_r;
  logic                      busy_r;
  logic                      gen_sda_r;
  logic                      gen_scl_r;
  logic                      ack_r;
  logic                      post_v;
  logic                      own_v;
  logic                      gcm_v;
  logic                      wb_req;
  logic                      wr_ctl;
  logic                      wr_dat;
  logic                      wr_adr;
  logic                      release_v;
  logic                      bus_start;
  logic                      rx_cap;

  // ----------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------
  assign wb_req    = cyc_i && stb_i && !ack_r;
  assign wr_ctl    = wb_req && we_i && sel_i[0] && (adr_i == `TW_OFS_CONTROL);
  assign wr_dat    = wb_req && we_i && sel_i[0] && (adr_i == `TW_OFS_DATA);
  assign wr_adr    = wb_req && we_i && sel_i[0] && (adr_i == `TW_OFS_ADDRESS);
  assign release_v = wr_ctl && dat_i[`TW_CTL_FLAG] && flag_r;
  // our own generated start must not look like a master addressing us
  assign bus_start = ev.start && !gen_sda_r;
  assign rx_cap    = ev.scl_fall && (cnt_r == `TW_CNT_ACK) && (state_r == twowire_pkg::ST_RX);

  // address compare: both need ack enable, general call also needs its enable
  assign own_v = en_r && acken_r && (sh_r[7:1] == adr_r[7:1]);
  assign gcm_v = en_r && acken_r && adr_r[`TW_ADR_GCE]
                 && (sh_r == `TW_GC_ADDRESS);

  // ----------------------------------------------------------------------
  // status posting decode
  // ----------------------------------------------------------------------
  always_comb begin
    post_v    = 1'b0;
    post_code = `TW_ST_NONE;
    if ((bus_start || ev.stop) && state_r == twowire_pkg::ST_RX) begin
      post_v    = 1'b1;
      post_code = `TW_ST_STOP;
    end else if (ev.scl_fall && cnt_r == `TW_CNT_DONE) begin
      case (state_r)
        twowire_pkg::ST_ADDR: begin
          post_v = 1'b1;
          if (rw_r) begin
            post_code = arb_r ? `TW_ST_ARB_SLA_R : `TW_ST_SLA_R;
          end else if (gc_r) begin
            post_code = arb_r ? `TW_ST_ARB_GC : `TW_ST_GC;
          end else begin
            post_code = arb_r ? `TW_ST_ARB_SLA_W : `TW_ST_SLA_W;
          end
        end
        twowire_pkg::ST_RX: begin
          post_v = 1'b1;
          if (gc_r) begin
            post_code = ackgiven_r ? `TW_ST_GC_ACK : `TW_ST_GC_NACK;
          end else begin
            post_code = ackgiven_r ? `TW_ST_RX_ACK : `TW_ST_RX_NACK;
          end
        end
        twowire_pkg::ST_TX: begin
          post_v = 1'b1;
          if (nack_r) begin
            post_code = `TW_ST_TX_NACK;
          end else begin
            post_code = last_r ? `TW_ST_TX_LAST : `TW_ST_TX_ACK;
          end
        end
        default: begin
          post_v    = 1'b0;
          post_code = `TW_ST_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // slave bit engine
  // ----------------------------------------------------------------------
  // bits are sampled on scl rise and changed on scl fall; cnt_r counts rises
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_r) begin
      state_r    <= twowire_pkg::ST_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      sda_drv_r  <= 1'b0;
      gc_r       <= 1'b0;
      rw_r       <= 1'b0;
      last_r     <= 1'b0;
      ackgiven_r <= 1'b0;
      nack_r     <= 1'b0;
    end else if (bus_start) begin
      state_r   <= twowire_pkg::ST_ADDR;  // monitored even when ack enable is low
      cnt_r     <= 4'h0;
      sda_drv_r <= 1'b0;
    end else if (ev.stop) begin
      state_r   <= twowire_pkg::ST_IDLE;
      sda_drv_r <= 1'b0;
    end else if (state_r != twowire_pkg::ST_IDLE) begin
      // transmit: first bit goes out while the clock is still stretched
      if (release_v && state_r == twowire_pkg::ST_TX && cnt_r == 4'h0) begin
        sda_drv_r <= !data_r[7];
        sh_r      <= {data_r[6:0], 1'b1};
        last_r    <= !dat_i[`TW_CTL_ACKEN];
      end
      if (ev.scl_rise && cnt_r != `TW_CNT_DONE) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == `TW_CNT_ACK) begin
          nack_r <= ev.sda;
        end else if (state_r != twowire_pkg::ST_TX) begin
          sh_r <= {sh_r[6:0], ev.sda};
        end
      end
      if (ev.scl_fall) begin
        case (cnt_r)
          `TW_CNT_ACK: begin
            if (state_r == twowire_pkg::ST_ADDR) begin
              if (own_v || gcm_v) begin
                sda_drv_r <= 1'b1;
                rw_r      <= sh_r[0];
                gc_r      <= gcm_v && !own_v;
              end else begin
                state_r   <= twowire_pkg::ST_IDLE;
                sda_drv_r <= 1'b0;
              end
            end else if (state_r == twowire_pkg::ST_RX) begin
              sda_drv_r  <= acken_r;
              ackgiven_r <= acken_r;
            end else begin
              sda_drv_r <= 1'b0;  // let the master answer
            end
          end
          `TW_CNT_DONE: begin
            sda_drv_r <= 1'b0;
            cnt_r     <= 4'h0;
            if (state_r == twowire_pkg::ST_ADDR) begin
              state_r <= rw_r ? twowire_pkg::ST_TX : twowire_pkg::ST_RX;
            end else if (state_r == twowire_pkg::ST_RX && !ackgiven_r) begin
              state_r <= twowire_pkg::ST_IDLE;
            end else if (state_r == twowire_pkg::ST_TX && (last_r || nack_r)) begin
              state_r <= twowire_pkg::ST_IDLE;
            end
          end
          default: begin
            if (state_r == twowire_pkg::ST_TX && cnt_r < `TW_CNT_ACK) begin
              sda_drv_r <= !sh_r[7];
              sh_r      <= {sh_r[6:0], 1'b1};
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // flag, status and arbitration memory
  // ----------------------------------------------------------------------
  // a posting in the same cycle as the software clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (post_v) begin
      flag_r <= 1'b1;
    end else if (release_v) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= `TW_ST_NONE;
    end else if (post_v) begin
      status_r <= post_code & `TW_PRESC_MASK;
    end else if (release_v) begin
      status_r <= `TW_ST_NONE;
    end
  end

  // lost arbitration is remembered until the next address posting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_r <= 1'b0;
    end else if (arb_lost_i) begin
      arb_r <= 1'b1;
    end else if (post_v && state_r == twowire_pkg::ST_ADDR) begin
      arb_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acken_r <= 1'b0;
      sta_r   <= 1'b0;
      sto_r   <= 1'b0;
      en_r    <= 1'b0;
      ie_r    <= 1'b0;
    end else if (wr_ctl) begin
      acken_r <= dat_i[`TW_CTL_ACKEN];
      sta_r   <= dat_i[`TW_CTL_STA];
      sto_r   <= dat_i[`TW_CTL_STO];
      en_r    <= dat_i[`TW_CTL_EN];
      ie_r    <= dat_i[`TW_CTL_IE];
    end
  end

  // data written while the flag is low is refused and flagged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wc_r <= 1'b0;
    end else if (wr_dat) begin
      wc_r <= !flag_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_r <= `TW_DAT_RST;
    end else if (rx_cap) begin
      data_r <= sh_r;
    end else if (wr_dat && flag_r) begin
      data_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adr_r <= `TW_ADR_RST;
    end else if (wr_adr) begin
      adr_r <= dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // start generation once the bus is free
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else if (ev.start) begin
      busy_r <= 1'b1;
    end else if (ev.stop) begin
      busy_r <= 1'b0;
    end
  end

  // the bus is then held with both lines low for the master section to take over
  always_ff @(posedge clk_i) begin
    if (rst_i || !sta_r || !en_r) begin
      gen_sda_r <= 1'b0;
      gen_scl_r <= 1'b0;
      gen_cnt_r <= 8'h00;
    end else if (!gen_sda_r) begin
      if (!flag_r && !busy_r && state_r == twowire_pkg::ST_IDLE) begin
        gen_sda_r <= 1'b1;
      end
    end else if (gen_cnt_r == HD_STA_CYC[7:0]) begin
      gen_scl_r <= 1'b1;
    end else begin
      gen_cnt_r <= gen_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // wishbone answer, one wait state on every access
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req) begin
        case (adr_i)
          `TW_OFS_CONTROL: dat_o <= {24'h00_0000, flag_r, acken_r, sta_r, sto_r,
                                     wc_r, en_r, 1'b0, ie_r};
          `TW_OFS_STATUS:  dat_o <= {24'h00_0000, status_r};
          `TW_OFS_DATA:    dat_o <= {24'h00_0000, data_r};
          `TW_OFS_ADDRESS: dat_o <= {24'h00_0000, adr_r};
          default:         dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign ack_o = ack_r;

  // ----------------------------------------------------------------------
  // open-drain pins
  // ----------------------------------------------------------------------
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  // the clock stays low while software owes an answer to an addressed transfer
  assign scl_oe_o = (flag_r && state_r != twowire_pkg::ST_IDLE) || gen_scl_r;
  assign sda_oe_o = sda_drv_r || gen_sda_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_prescaler_zero;
    post_v |=> status_r[2:0] == 3'h0 && flag_r;
  endproperty
  a_prescaler_zero: assert property (p_prescaler_zero) else $error("prescaler bits set");

  property p_gc_ack;
    (state_r == twowire_pkg::ST_RX && gc_r && ackgiven_r && ev.scl_fall
      && cnt_r == `TW_CNT_DONE) |=> status_r == 8'h90 && state_r == twowire_pkg::ST_RX;
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general call data not posted");

  property p_gc_nack;
    (state_r == twowire_pkg::ST_RX && gc_r && !ackgiven_r && ev.scl_fall
      && cnt_r == `TW_CNT_DONE) |=> status_r == 8'h98 && state_r == twowire_pkg::ST_IDLE;
  endproperty
  a_gc_nack: assert property (p_gc_nack) else $error("unacked general call wrong");

  property p_stop_addressed;
    (state_r == twowire_pkg::ST_RX && ev.stop) |=> status_r == 8'hA0
      && state_r == twowire_pkg::ST_IDLE && !sda_oe_o;
  endproperty
  a_stop_addressed: assert property (p_stop_addressed) else $error("stop while addressed");

  property p_no_ack_disabled;
    (state_r == twowire_pkg::ST_ADDR && ev.scl_fall && cnt_r == `TW_CNT_ACK && !acken_r)
      |=> state_r == twowire_pkg::ST_IDLE ##1 !sda_oe_o;
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("address acked");

  property p_gc_ignored;
    (state_r == twowire_pkg::ST_ADDR && ev.scl_fall && cnt_r == `TW_CNT_ACK
      && sh_r == 8'h00 && !adr_r[0] && adr_r[7:1] != 7'h00) |=> !sda_drv_r;
  endproperty
  a_gc_ignored: assert property (p_gc_ignored) else $error("general call acked");

  property p_read_enters_tx;
    (state_r == twowire_pkg::ST_ADDR && ev.scl_fall && cnt_r == `TW_CNT_DONE && rw_r)
      |=> state_r == twowire_pkg::ST_TX && (status_r == 8'hA8 || status_r == 8'hB0);
  endproperty
  a_read_enters_tx: assert property (p_read_enters_tx) else $error("read not in tx");

  property p_arb_read;
    (state_r == twowire_pkg::ST_ADDR && ev.scl_fall && cnt_r == `TW_CNT_DONE && rw_r && arb_r)
      |=> status_r == 8'hB0 && !arb_r;
  endproperty
  a_arb_read: assert property (p_arb_read) else $error("lost arbitration read code");

  property p_last_byte;
    (state_r == twowire_pkg::ST_TX && last_r && ev.scl_fall && cnt_r == `TW_CNT_DONE)
      |=> state_r == twowire_pkg::ST_IDLE && !sda_oe_o
          && (status_r == 8'hC0 || status_r == 8'hC8);
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("last byte not closed");

  property p_released_after_last;
    ($rose(flag_r) && (status_r == 8'hC0 || status_r == 8'hC8)) |-> !sda_drv_r [*3];
  endproperty
  a_released_after_last: assert property (p_released_after_last) else $error("sda held");

  // the synchronised line itself must stay low, not only our enable
  property p_stretch;
    (flag_r && state_r != twowire_pkg::ST_IDLE) [*4] |-> !lines_s[1];
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not stretched");

  c_gc_data: cover property (post_v && post_code == 8'h90);
  c_tx_nack: cover property (post_v && post_code == 8'hC0);
  c_stop_rx: cover property (post_v && post_code == 8'hA0);
  c_start_gen: cover property ($rose(gen_scl_r));
endmodule : twowire_slave_engine

/* rtl/twowire_map.svh */
// register offsets, field positions, status codes and timing of the two-wire slave engine
`ifndef TWOWIRE_MAP_SVH
`define TWOWIRE_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets on the wishbone bus
// ----------------------------------------------------------------------
`define TW_OFS_CONTROL  4'h0
`define TW_OFS_STATUS   4'h4
`define TW_OFS_DATA     4'h8
`define TW_OFS_ADDRESS  4'hC

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TW_CTL_FLAG     7
`define TW_CTL_ACKEN    6
`define TW_CTL_STA      5
`define TW_CTL_STO      4
`define TW_CTL_WC       3
`define TW_CTL_EN       2
`define TW_CTL_IE       0
`define TW_ADR_GCE      0
`define TW_ADR_RST      8'h00
`define TW_DAT_RST      8'hFF
`define TW_PRESC_MASK   8'hF8
`define TW_GC_ADDRESS   8'h00

// ----------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------
`define TW_ST_SLA_W     8'h60
`define TW_ST_ARB_SLA_W 8'h68
`define TW_ST_GC        8'h70
`define TW_ST_ARB_GC    8'h78
`define TW_ST_RX_ACK    8'h80
`define TW_ST_RX_NACK   8'h88
`define TW_ST_GC_ACK    8'h90
`define TW_ST_GC_NACK   8'h98
`define TW_ST_STOP      8'hA0
`define TW_ST_SLA_R     8'hA8
`define TW_ST_ARB_SLA_R 8'hB0
`define TW_ST_TX_ACK    8'hB8
`define TW_ST_TX_NACK   8'hC0
`define TW_ST_TX_LAST   8'hC8
`define TW_ST_NONE      8'hF8

// ----------------------------------------------------------------------
// bit counter marks and timing
// ----------------------------------------------------------------------
`define TW_CNT_ACK      4'h8
`define TW_CNT_DONE     4'h9
`define TW_CLK_NS       25
`define TW_HD_STA_NS    4000
`define TW_HD_STA_CYC   ((`TW_HD_STA_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

/* rtl/twowire_pkg.sv */
// types shared by the two-wire slave engine modules
package twowire_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_RX   = 2'h3,
    ST_TX   = 2'h2
  } slave_state_t;
  typedef logic [7:0] byte_t;
endpackage : twowire_pkg

/* rtl/twowire_evt_if.sv */
// bus line events passed from the line watcher to the slave engine
`timescale 1ns/1ps
interface twowire_evt_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport dst (input scl_rise, scl_fall, start, stop, sda);
endinterface : twowire_evt_if

/* rtl/twowire_sync.sv */
// two-flop synchroniser for the serial bus lines
`timescale 1ns/1ps
module twowire_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // idle bus lines are high, so both stages reset high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : twowire_sync

/* rtl/twowire_line_events.sv */
// edge, start and stop detection on the synchronised bus lines
`timescale 1ns/1ps
module twowire_line_events (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  twowire_evt_if.src  ev
);
  logic scl_q_r;
  logic sda_q_r;

  // previous line levels for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // start and stop need scl high on both samples, so they never meet an scl edge
  assign ev.scl_rise = scl_i && !scl_q_r;
  assign ev.scl_fall = !scl_i && scl_q_r;
  assign ev.start    = scl_i && scl_q_r && sda_q_r && !sda_i;
  assign ev.stop     = scl_i && scl_q_r && !sda_q_r && sda_i;
  assign ev.sda      = sda_i;
endmodule : twowire_line_events

/* verif/twowire_master_model.sv */
// behavioural two-wire bus master
`timescale 1ns/1ps
module twowire_master_model (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  int n_stuck;
  // both lines released at power up
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    n_stuck = 0;
  end
  // half of the 200 ns link period
  task hp;
    repeat (4) @(posedge clk_i);
  endtask : hp
  // bounded wait on scl: the slave may stretch; a clock held too long counts as stuck
  task bitx(input logic b, output logic r);
    sda_low_o <= !b;
    hp;
    scl_low_o <= 1'b0;
    for (int i = 0; i < 2000 && !scl_i && n_stuck == 0; i++) @(posedge clk_i);
    if (!scl_i) n_stuck++;
    repeat (3) @(posedge clk_i);
    r = sda_i;
    scl_low_o <= 1'b1;
  endtask : bitx
  // msb first, ninth bit is the acknowledge
  task xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(a, ar);
  endtask : xbyte
  task start;
    sda_low_o <= 1'b0;
    hp;
    scl_low_o <= 1'b0;
    hp;
    sda_low_o <= 1'b1;
    hp;
    scl_low_o <= 1'b1;
  endtask : start
  task stop;
    sda_low_o <= 1'b1;
    hp;
    scl_low_o <= 1'b0;
    hp;
    sda_low_o <= 1'b0;
    hp;
  endtask : stop
endmodule : twowire_master_model

/* verif/twowire_slave_engine_tb_top.sv */
// self-checking bench of the two-wire slave engine
`timescale 1ns/1ps
module twowire_slave_engine_tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, ak;
  logic [3:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [15:0] lf;
  logic [7:0] rb, rx, d;
  logic [6:0] a7;
  logic ml_scl, ml_sda, arb;
  int n_mismatch, compares;
  // open-drain lines with pull-ups
  wire scl = !(scl_oe_o || ml_scl);
  wire sda = !(sda_oe_o || ml_sda);
  twowire_slave_engine dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1),
    .dat_i, .dat_o, .ack_o, .arb_lost_i(arb), .scl_i(scl), .scl_o, .scl_oe_o,
    .sda_i(sda), .sda_o, .sda_oe_o);
  twowire_master_model m (.clk_i, .scl_i(scl), .sda_i(sda), .scl_low_o(ml_scl),
    .sda_low_o(ml_sda));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task give_verdict;
    n_mismatch += m.n_stuck;
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one classic cycle; a lost ack ends the run
  task wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    int t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, v};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_mismatch++;
      give_verdict;
    end
    rb = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // poll the flag under a bound, then compare the status code
  task wflag(input logic [7:0] e);
    int t;
    t = 0;
    do begin
      wb(1'b0, 4'h0, 8'h00);
      t++;
    end while (rb[7] !== 1'b1 && t < 400);
    if (rb[7] !== 1'b1) begin
      n_mismatch++;
      give_verdict;
    end
    wb(1'b0, 4'h4, 8'h00);
    chk("status", e, rb);
  endtask : wflag
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    dat_i = 32'h0;
    arb = 1'b0;
    n_mismatch = 0;
    compares = 0;
    lf = nx(16'h9E80);
    a7 = {1'b1, lf[5:0]};
    d = lf[15:8];
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h4, 8'h00);
    chk("status", 8'hF8, rb);
    wb(1'b0, 4'h6, 8'h00);
    chk("unmapped", 8'h00, rb);
    // general call with its enable off, wrong address, own address with acknowledge off
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 4'hC, {a7, k > 0});
      wb(1'b1, 4'h0, k == 2 ? 8'h04 : 8'h44);
      m.start;
      m.xbyte(k == 0 ? 8'h00 : {a7 ^ {6'h0, k == 1}, 1'b0}, 1'b1, rx, ak);
      chk("nack", 1'b1, ak);
      m.stop;
    end
    wb(1'b1, 4'h0, 8'h44);
    m.start;
    m.xbyte({a7, 1'b0}, 1'b1, rx, ak);
    chk("ack", 1'b0, ak);
    wflag(8'h60);
    wb(1'b1, 4'h0, 8'hC4);
    m.xbyte(d, 1'b1, rx, ak);
    wflag(8'h80);
    wb(1'b0, 4'h8, 8'h00);
    chk("rx", d, rb);
    wb(1'b1, 4'h0, 8'hC4);
    m.stop;
    wflag(8'hA0);
    wb(1'b1, 4'h0, 8'hC4);
    $display("receive test done");
    m.start;
    m.xbyte(8'h00, 1'b1, rx, ak);
    wflag(8'h70);
    wb(1'b1, 4'h0, 8'hC4);
    m.xbyte(d, 1'b1, rx, ak);
    wflag(8'h90);
    wb(1'b1, 4'h0, 8'h84);
    m.xbyte(~d, 1'b1, rx, ak);
    chk("nack", 1'b1, ak);
    wflag(8'h98);
    wb(1'b1, 4'h0, 8'hC4);
    m.stop;
    wb(1'b0, 4'h4, 8'h00);
    chk("status", 8'hF8, rb);
    $display("general call test done");
    m.start;
    m.xbyte({a7, 1'b1}, 1'b1, rx, ak);
    wflag(8'hA8);
    wb(1'b1, 4'h8, d);
    wb(1'b1, 4'h0, 8'h84);
    m.xbyte(8'hFF, 1'b0, rx, ak);
    chk("tx", d, rx);
    wflag(8'hC8);
    wb(1'b1, 4'h0, 8'hC4);
    m.xbyte(8'hFF, 1'b1, rx, ak);
    chk("idle", 8'hFF, rx);
    m.stop;
    $display("transmit test done");
    // lost arbitration, then read: one acked byte, then a last byte that gets nack
    arb <= 1'b1;
    @(posedge clk_i);
    arb <= 1'b0;
    m.start;
    m.xbyte({a7, 1'b1}, 1'b1, rx, ak);
    wflag(8'hB0);
    wb(1'b1, 4'h8, ~d);
    wb(1'b1, 4'h0, 8'hC4);
    m.xbyte(8'hFF, 1'b0, rx, ak);
    chk("tx", ~d, rx);
    wflag(8'hB8);
    wb(1'b1, 4'h8, d);
    wb(1'b1, 4'h0, 8'hA4);
    m.xbyte(8'hFF, 1'b1, rx, ak);
    chk("tx", d, rx);
    wflag(8'hC0);
    // start request: both lines held low once the bus is free
    wb(1'b1, 4'h0, 8'hE4);
    m.stop;
    repeat (200) @(posedge clk_i);
    chk("start", 8'h00, {6'h0, scl, sda});
    $display("arbitration and start test done");
    give_verdict;
  end
endmodule : twowire_slave_engine_tb_top
